// ==== scdc_top.sv ====
// Clock generator control: protected standby clock control register, divider, stop and settle.
// Assumes a synchronous decoder on ref_clk and asynchronous oscillator and wake pins.
`timescale 1ns/1ps
`include "scdc_regs.svh"
module scdc_top #(
    parameter int SETTLE_SHIFT = `SCDC_SETTLE_SHIFT_BASE
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register write and read from the instruction decoder
    input wire scdc_pkg::scdc_wr_s wr,
    input wire logic rd_en,
    input wire logic rd_settle_cfg,
    output logic [7:0] rd_data,
    // Operand error interrupt
    output logic op_error_pulse,
    output logic [19:0] op_error_ret_addr,
    // Oscillator pins
    input wire logic osc_in_pin,
    input wire logic osc_out_pin_i,
    output logic osc_out_pin_o,
    output logic osc_out_pin_oe,
    output logic osc_amp_en,
    // Wake sources and their interrupt-controller state
    input wire logic nmi_pin,
    input wire logic irq4_pin,
    input wire logic irq5_pin,
    input wire logic irq4_masked,
    input wire logic irq4_macro_en,
    input wire logic irq5_masked,
    input wire logic irq5_macro_en,
    // Clocks and status
    output logic sys_clk,
    output logic halt_req,
    output logic stop_active,
    output logic div_change_pending
);
    logic [7:0] standby_clock_control_reg;
    logic [7:0] oscillation_settle_config_reg;
    logic [2:0] x1_sync_reg;
    logic [2:0] x2_sync_reg;
    logic [1:0] nmi_sync_reg;
    logic [1:0] irq4_sync_reg;
    logic [1:0] irq5_sync_reg;
    logic [2:0] wake_prev_reg;
    logic [3:0] div_cnt_reg;
    logic [1:0] div_active_reg;
    logic [19:0] settle_cnt_reg;
    logic sys_clk_reg;
    scdc_pkg::scdc_state_e state_reg;
    scdc_pkg::scdc_state_e state_next;
    logic external_clock_select;
    logic fxx_rise;
    logic standby_clock_control_wr_ok;
    logic standby_clock_control_wr_bad;
    logic oscillation_settle_config_wr_ok;
    logic wake;
    logic period_end;
    logic [1:0] div_req;

    // Last divider count of a full period for the given ratio
    function automatic logic [3:0] div_last(input logic [1:0] sel);
        case (sel)
            2'h0: div_last = 4'h1;
            2'h1: div_last = 4'h3;
            2'h2: div_last = 4'h7;
            default: div_last = 4'hf;
        endcase
    endfunction : div_last

    // Settle length in oscillator periods; field value zero picks the default
    function automatic logic [19:0] settle_len(input logic [2:0] sel);
        logic [2:0] step;
        step = (sel == 3'h0) ? `SCDC_SETTLE_DEFAULT_STEP : sel;
        settle_len = 20'(20'h1 << (SETTLE_SHIFT + int'(step) - 1));
    endfunction : settle_len

    assign external_clock_select = oscillation_settle_config_reg[`SCDC_OSCILLATION_SETTLE_CONFIG_EXTERNAL_CLOCK_SELECT_BIT];
    assign div_req = standby_clock_control_reg[`SCDC_STANDBY_CLOCK_CONTROL_DIV_HI:`SCDC_STANDBY_CLOCK_CONTROL_DIV_LO];

    //------------------------------------------------------------------
    // Register writes
    //------------------------------------------------------------------
    assign standby_clock_control_wr_ok = wr.valid && !wr.to_settle_cfg && wr.kind == scdc_pkg::SCDC_WR_DEDICATED
        && wr.data == ~wr.data_check;
    assign standby_clock_control_wr_bad = wr.valid && !wr.to_settle_cfg && wr.kind == scdc_pkg::SCDC_WR_DEDICATED
        && wr.data != ~wr.data_check;
    assign oscillation_settle_config_wr_ok = wr.valid && wr.to_settle_cfg && wr.kind == scdc_pkg::SCDC_WR_MOV8;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            standby_clock_control_reg <= `SCDC_STANDBY_CLOCK_CONTROL_RESET;
        else if (standby_clock_control_wr_ok)
            standby_clock_control_reg <= wr.data;
        else if (state_reg == scdc_pkg::SCDC_SETTLE && settle_cnt_reg == settle_len(
            oscillation_settle_config_reg[`SCDC_OSCILLATION_SETTLE_CONFIG_SEL_HI:`SCDC_OSCILLATION_SETTLE_CONFIG_SEL_LO]))
            standby_clock_control_reg[`SCDC_STANDBY_CLOCK_CONTROL_STOP_BIT] <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            oscillation_settle_config_reg <= `SCDC_OSCILLATION_SETTLE_CONFIG_RESET;
        else if (oscillation_settle_config_wr_ok)
            oscillation_settle_config_reg <= wr.data;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            op_error_pulse <= 1'b0;
            op_error_ret_addr <= 20'h00000;
        end
        else
        begin
            op_error_pulse <= standby_clock_control_wr_bad;
            if (standby_clock_control_wr_bad)
                op_error_ret_addr <= wr.insn_addr;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            rd_data <= 8'h00;
        else if (rd_en)
            rd_data <= rd_settle_cfg ? oscillation_settle_config_reg : standby_clock_control_reg;
    end

    //------------------------------------------------------------------
    // Pin synchronisers and oscillator edge
    //------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            x1_sync_reg <= 3'h0;
            x2_sync_reg <= 3'h0;
            nmi_sync_reg <= 2'h0;
            irq4_sync_reg <= 2'h0;
            irq5_sync_reg <= 2'h0;
            wake_prev_reg <= 3'h0;
        end
        else
        begin
            x1_sync_reg <= {x1_sync_reg[1:0], osc_in_pin};
            x2_sync_reg <= {x2_sync_reg[1:0], osc_out_pin_i};
            nmi_sync_reg <= {nmi_sync_reg[0], nmi_pin};
            irq4_sync_reg <= {irq4_sync_reg[0], irq4_pin};
            irq5_sync_reg <= {irq5_sync_reg[0], irq5_pin};
            wake_prev_reg <= {irq5_sync_reg[1], irq4_sync_reg[1], nmi_sync_reg[1]};
        end
    end

    // External select takes the output pin, otherwise the input pin
    assign fxx_rise = external_clock_select ? (x2_sync_reg[1] && !x2_sync_reg[2])
        : (x1_sync_reg[1] && !x1_sync_reg[2]);

    // Resonator amplifier: inverts the input pin onto the output pin
    assign osc_amp_en = !external_clock_select && state_reg != scdc_pkg::SCDC_STOP;
    assign osc_out_pin_oe = osc_amp_en;
    assign osc_out_pin_o = !osc_in_pin;

    //------------------------------------------------------------------
    // Stop, wake and settle sequence
    //------------------------------------------------------------------
    assign wake = (nmi_sync_reg[1] && !wake_prev_reg[0])
        || (irq4_sync_reg[1] && !wake_prev_reg[1] && !irq4_masked && !irq4_macro_en)
        || (irq5_sync_reg[1] && !wake_prev_reg[2] && !irq5_masked && !irq5_macro_en);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            scdc_pkg::SCDC_RUN:
                if (standby_clock_control_reg[`SCDC_STANDBY_CLOCK_CONTROL_STOP_BIT])
                    state_next = scdc_pkg::SCDC_STOP;
            scdc_pkg::SCDC_STOP:
                if (wake)
                    state_next = scdc_pkg::SCDC_SETTLE;
            scdc_pkg::SCDC_SETTLE:
                if (settle_cnt_reg == settle_len(oscillation_settle_config_reg[`SCDC_OSCILLATION_SETTLE_CONFIG_SEL_HI:`SCDC_OSCILLATION_SETTLE_CONFIG_SEL_LO]))
                    state_next = scdc_pkg::SCDC_RUN;
            default:
                state_next = scdc_pkg::SCDC_RUN;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            state_reg <= scdc_pkg::SCDC_RUN;
        else
            state_reg <= state_next;
    end

    // Counts oscillator periods while the oscillator restarts
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || state_reg != scdc_pkg::SCDC_SETTLE)
            settle_cnt_reg <= 20'h00000;
        else if (fxx_rise)
            settle_cnt_reg <= settle_cnt_reg + 20'h00001;
    end

    //------------------------------------------------------------------
    // Frequency divider
    //------------------------------------------------------------------
    assign period_end = fxx_rise && div_cnt_reg == div_last(div_active_reg);

    // A new ratio takes over only at the end of an old full period
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            div_cnt_reg <= 4'h0;
            div_active_reg <= 2'(`SCDC_STANDBY_CLOCK_CONTROL_RESET >> `SCDC_STANDBY_CLOCK_CONTROL_DIV_LO);
        end
        else if (state_reg != scdc_pkg::SCDC_RUN)
            div_cnt_reg <= 4'h0;
        else if (period_end)
        begin
            div_cnt_reg <= 4'h0;
            div_active_reg <= div_req;
        end
        else if (fxx_rise)
            div_cnt_reg <= div_cnt_reg + 4'h1;
    end

    // High for the second half of each divided period
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            sys_clk_reg <= 1'b0;
        else
            sys_clk_reg <= div_cnt_reg[div_active_reg];
    end

    assign sys_clk = sys_clk_reg;
    assign halt_req = standby_clock_control_reg[`SCDC_STANDBY_CLOCK_CONTROL_HALT_BIT];
    assign stop_active = state_reg != scdc_pkg::SCDC_RUN;
    assign div_change_pending = div_active_reg != div_req;

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    logic [4:0] switch_wait_reg;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || !div_change_pending || state_reg != scdc_pkg::SCDC_RUN)
            switch_wait_reg <= 5'h00;
        else if (fxx_rise)
            switch_wait_reg <= switch_wait_reg + 5'h01;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    standby_clock_control_commit_a: assert property (standby_clock_control_wr_ok |=> standby_clock_control_reg == $past(wr.data))
        else $error("checked write not committed");
    standby_clock_control_reject_a: assert property (standby_clock_control_wr_bad && !$past(standby_clock_control_wr_ok) |=> op_error_pulse
        && op_error_ret_addr == $past(wr.insn_addr))
        else $error("bad write did not raise error");
    other_ignored_a: assert property (wr.valid && wr.kind == scdc_pkg::SCDC_WR_OTHER
        && state_reg == scdc_pkg::SCDC_RUN |=> $stable(standby_clock_control_reg) && $stable(oscillation_settle_config_reg)
        && !op_error_pulse)
        else $error("ignored write changed state");
    oscillation_settle_config_write_a: assert property (wr.valid && wr.to_settle_cfg && wr.kind != scdc_pkg::SCDC_WR_MOV8
        |=> $stable(oscillation_settle_config_reg))
        else $error("settle config written by wrong form");
    amp_off_a: assert property (external_clock_select || state_reg == scdc_pkg::SCDC_STOP |-> !osc_amp_en
        && !osc_out_pin_oe)
        else $error("amplifier on when it must be off");
    stop_entry_a: assert property (state_reg == scdc_pkg::SCDC_RUN && standby_clock_control_reg[0]
        |=> state_reg == scdc_pkg::SCDC_STOP)
        else $error("stop not entered");
    switch_bound_a: assert property (switch_wait_reg <= 5'(`SCDC_SWITCH_MAX_DIV4))
        else $error("ratio change took too long");
    old_ratio_a: assert property (div_change_pending && !period_end
        && state_reg == scdc_pkg::SCDC_RUN |=> $stable(div_active_reg))
        else $error("ratio switched mid period");
    settle_hold_a: assert property (state_reg == scdc_pkg::SCDC_SETTLE
        |-> div_cnt_reg == 4'h0 ##1 !sys_clk_reg)
        else $error("clock released during settle");
endmodule : scdc_top

// ==== scdc_regs.svh ====
// Constants of the system clock divider control block.
// Assumes one clock (ref_clk) and the CPU write/read port of scdc_top.
`ifndef SCDC_REGS_SVH
`define SCDC_REGS_SVH
`define SCDC_STANDBY_CLOCK_CONTROL_RESET 8'h30
`define SCDC_OSCILLATION_SETTLE_CONFIG_RESET 8'h00
`define SCDC_STANDBY_CLOCK_CONTROL_STOP_BIT 0
`define SCDC_STANDBY_CLOCK_CONTROL_HALT_BIT 1
`define SCDC_STANDBY_CLOCK_CONTROL_DIV_LO 4
`define SCDC_STANDBY_CLOCK_CONTROL_DIV_HI 5
`define SCDC_OSCILLATION_SETTLE_CONFIG_EXTERNAL_CLOCK_SELECT_BIT 7
`define SCDC_OSCILLATION_SETTLE_CONFIG_SEL_LO 0
`define SCDC_OSCILLATION_SETTLE_CONFIG_SEL_HI 2
`define SCDC_SETTLE_SHIFT_BASE 12
`define SCDC_SETTLE_DEFAULT_STEP 3'h4
`define SCDC_SWITCH_MAX_DIV2 22
`define SCDC_SWITCH_MAX_DIV4 24
`define SCDC_SWITCH_MAX_DIV8 16
`define SCDC_SWITCH_MAX_DIV16 16
`endif

// ==== scdc_pkg.sv ====
// Types of the system clock divider control block.
// Assumes scdc_regs.svh for the numbers.
package scdc_pkg;
    typedef enum logic [1:0] {
        SCDC_WR_DEDICATED = 2'h0,
        SCDC_WR_MOV8 = 2'h1,
        SCDC_WR_OTHER = 2'h2
    } scdc_wr_kind_e;

    typedef enum logic [2:0] {
        SCDC_RUN = 3'h1,
        SCDC_STOP = 3'h2,
        SCDC_SETTLE = 3'h4
    } scdc_state_e;

    // One register write from the instruction decoder
    typedef struct packed {
        logic valid;
        logic to_settle_cfg;
        scdc_wr_kind_e kind;
        logic [7:0] data;
        logic [7:0] data_check;
        logic [19:0] insn_addr;
    } scdc_wr_s;
endpackage : scdc_pkg

// ==== scdc_osc_model.sv ====
// Resonator or external clock source at the oscillator pins.
// Assumes the bench resolves the output pin from the design's enable.
`timescale 1ns/1ps
module scdc_osc_model (
    // Mode and amplifier state
    ext_mode,
    amp_en,
    // Pin drive
    osc_in_pin,
    osc_out_drv
);
    input wire logic ext_mode;
    input wire logic amp_en;
    output logic osc_in_pin;
    output logic osc_out_drv;
    initial osc_in_pin = 1'b0;
    // Resonator swings only with its amplifier on, external source runs free
    always #100 if (amp_en || ext_mode) osc_in_pin = ~osc_in_pin;
    // External source drives the inverted phase on the output pin
    assign osc_out_drv = ~osc_in_pin;
endmodule : scdc_osc_model

// ==== system_clock_divider_control_test.sv ====
// Self-checking bench for scdc_top with an oscillator model.
// Assumes a 200 ns oscillator period, ten ref_clk cycles.
`timescale 1ns/1ps
module system_clock_divider_control_test;
    logic ref_clk, rst_n, rd_en, rd_settle_cfg, nmi_pin, irq4_pin, irq4_masked, ext_mode;
    scdc_pkg::scdc_wr_s wr;
    logic [7:0] rd_data, v, d;
    logic [19:0] op_error_ret_addr, a;
    logic op_error_pulse, osc_in_pin, osc_out_drv, osc_out_pin_o, osc_out_pin_oe, osc_amp_en;
    logic sys_clk, halt_req, stop_active, div_change_pending, e, h;
    logic [1:0] r, old;
    int num_errors, tests_run, cycles, n, i, s;
    realtime t0;
    wire logic osc_out_wire = osc_out_pin_oe ? osc_out_pin_o : osc_out_drv;

    scdc_osc_model osc (.ext_mode(ext_mode), .amp_en(osc_amp_en),
        .osc_in_pin(osc_in_pin), .osc_out_drv(osc_out_drv));
    scdc_top #(.SETTLE_SHIFT(2)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .wr(wr),
        .rd_en(rd_en), .rd_settle_cfg(rd_settle_cfg), .rd_data(rd_data),
        .op_error_pulse(op_error_pulse), .op_error_ret_addr(op_error_ret_addr),
        .osc_in_pin(osc_in_pin), .osc_out_pin_i(osc_out_wire), .osc_out_pin_o(osc_out_pin_o),
        .osc_out_pin_oe(osc_out_pin_oe), .osc_amp_en(osc_amp_en), .nmi_pin(nmi_pin),
        .irq4_pin(irq4_pin), .irq5_pin(1'b0), .irq4_masked(irq4_masked),
        .irq4_macro_en(1'b0), .irq5_masked(1'b1), .irq5_macro_en(1'b0),
        .sys_clk(sys_clk), .halt_req(halt_req), .stop_active(stop_active),
        .div_change_pending(div_change_pending));

    always #10 ref_clk = ~ref_clk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function int div_cycles(input logic [1:0] f);
        return 20 << f;
    endfunction : div_cycles

    function int switch_limit(input logic [1:0] f);
        return (f == 2'h0 ? 22 : (f == 2'h1 ? 24 : 16)) * 10 + 10;
    endfunction : switch_limit

    task check(input logic [19:0] seen, input logic [19:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task wr_reg(input logic sc, input scdc_pkg::scdc_wr_kind_e k, input logic [7:0] dv,
        input logic [7:0] cv);
        @(posedge ref_clk);
        wr <= '{1'b1, sc, k, dv, cv, a};
        @(posedge ref_clk);
        wr.valid <= 1'b0;
        #1 e = op_error_pulse;
    endtask : wr_reg

    task rd_reg(input logic sc);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        rd_settle_cfg <= sc;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask : rd_reg

    task measure;
        @(posedge sys_clk);
        t0 = $realtime;
        @(posedge sys_clk);
        n = int'(($realtime - t0) / 20.0);
    endtask : measure

    task test_done;
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            num_errors++;
            test_done;
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        ref_clk = 0; rst_n = 0; wr = '0; rd_en = 0; rd_settle_cfg = 0; nmi_pin = 0;
        irq4_pin = 0; irq4_masked = 1; ext_mode = 0; a = '0;
        num_errors = 0; tests_run = 0; cycles = 0;
        void'($urandom(11));
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_reg(1'b0); check(v, 8'h30);
        rd_reg(1'b1); check(v, 8'h00);
        check(osc_amp_en, 1'b1);
        measure; check(n, 160);
        old = 2'h3;
        repeat (8)
        begin
            r = $urandom; h = $urandom; a = $urandom;
            d = {2'b00, r, 2'b00, h, 1'b0};
            wr_reg(1'b0, scdc_pkg::SCDC_WR_DEDICATED, d, ~d); check(e, 1'b0);
            i = 0;
            while (div_change_pending !== 1'b0 && i < 400)
            begin
                @(negedge ref_clk);
                i++;
            end
            check(i <= switch_limit(old), 1'b1);
            measure; check(n, div_cycles(r));
            rd_reg(1'b0); check(v, d);
            check(halt_req, h);
            old = r;
        end
        a = $urandom;
        wr_reg(1'b0, scdc_pkg::SCDC_WR_DEDICATED, 8'h10, 8'h10); check(e, 1'b1);
        check(op_error_ret_addr, a);
        wr_reg(1'b0, scdc_pkg::SCDC_WR_MOV8, 8'h00, 8'hff); check(e, 1'b0);
        wr_reg(1'b0, scdc_pkg::SCDC_WR_OTHER, 8'h00, 8'hff); check(e, 1'b0);
        rd_reg(1'b0); check(v, d);
        wr_reg(1'b1, scdc_pkg::SCDC_WR_OTHER, 8'h87, 8'h78);
        wr_reg(1'b1, scdc_pkg::SCDC_WR_DEDICATED, 8'h87, 8'h78);
        rd_reg(1'b1); check(v, 8'h00);
        // Masked line must not wake, then unmasked line and non-maskable line do
        for (s = 0; s < 3; s++)
        begin
            irq4_masked <= (s == 0);
            wr_reg(1'b0, scdc_pkg::SCDC_WR_DEDICATED, 8'h31, 8'hce);
            @(posedge ref_clk);
            #1 check(stop_active, 1'b1);
            check(osc_amp_en, 1'b0);
            @(posedge ref_clk);
            if (s == 2)
                nmi_pin <= 1'b1;
            else
                irq4_pin <= 1'b1;
            i = 0;
            while (stop_active !== 1'b0 && i < 1000)
            begin
                @(posedge ref_clk);
                if (i == 20)
                begin
                    nmi_pin <= 1'b0;
                    irq4_pin <= 1'b0;
                end
                @(negedge ref_clk);
                i++;
            end
            if (s == 0)
                check(stop_active, 1'b1);
            else
            begin
                check(i >= 315 && i <= 350, 1'b1);
                rd_reg(1'b0); check(v, 8'h30);
            end
        end
        ext_mode <= 1'b1;
        wr_reg(1'b1, scdc_pkg::SCDC_WR_MOV8, 8'h80, 8'h00);
        @(posedge ref_clk);
        #1 check(osc_amp_en, 1'b0);
        check(osc_out_pin_oe, 1'b0);
        rd_reg(1'b1); check(v, 8'h80);
        measure; check(n, 160);
        // Stop with the external source only after external select is set
        wr_reg(1'b0, scdc_pkg::SCDC_WR_DEDICATED, 8'h31, 8'hce);
        @(posedge ref_clk);
        #1 check(stop_active, 1'b1);
        @(posedge ref_clk);
        nmi_pin <= 1'b1;
        i = 0;
        while (stop_active !== 1'b0 && i < 1000)
        begin
            @(negedge ref_clk);
            i++;
        end
        check(stop_active, 1'b0);
        @(posedge ref_clk);
        nmi_pin <= 1'b0;
        test_done;
    end
endmodule : system_clock_divider_control_test
